/* File: bench/bmswc_host_model.sv */
// Purpose: external host reads
// Assumes: rd_sel is a one-cycle bench request
// Notes:   read data moves every cycle so stale values never match
`timescale 1ns/1ns
`default_nettype none
module bmswc_host_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // device status and request
    input  wire logic       load_allowed,
    input  wire logic [2:0] rd_sel,
    // port reads
    output logic            hpi_read,
    output logic            hss_read,
    output logic            spi_read,
    output logic [15:0]     host_rd_data_in
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {spi_read, hss_read, hpi_read} <= 3'h0;
            host_rd_data_in <= 16'h0;
        end else begin
            {spi_read, hss_read, hpi_read} <= rd_sel & {3{load_allowed}};
            host_rd_data_in <= host_rd_data_in + 16'h3a5b;
        end
    end
endmodule
`default_nettype wire

/* File: bench/bmswc_props.sv */
// Purpose: port checks
// Assumes: one clock
// Notes:   bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module bmswc_props #(
    parameter int unsigned MEM_AW      = 19,
    parameter logic [16:0] BOOT_CYCLES = 17'h14
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              rst_b,
    // watched ports
    input wire logic              load_allowed,
    input wire logic              asleep,
    input wire logic              cpu_run,
    input wire logic              pll_en,
    input wire logic              crystal_drive_output_en,
    input wire logic              booster_en,
    input wire logic              usb_xcvr_en,
    input wire logic [MEM_AW-1:0] mem_addr,
    input wire logic              pwr_ctrl_wr,
    input wire logic [15:0]       pwr_ctrl_wdata,
    input wire logic [7:0]        wake_enable,
    input wire logic              usb_resume,
    input wire logic              host_port_interrupt_line
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // cycles since release, saturating
    logic [16:0] since_rst;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            since_rst <= 17'h0;
        else if (since_rst != BOOT_CYCLES)
            since_rst <= since_rst + 17'h1;
    end
    logic [12:0] wake_wait;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            wake_wait <= 13'h0;
        else if (asleep || cpu_run)
            wake_wait <= {12'h0, asleep};
        else if (wake_wait != 13'h0)
            wake_wait <= wake_wait + 13'h1;
    end
    a_boot_not_early: assert property (load_allowed |-> since_rst == BOOT_CYCLES)
        else $error("load allowed early");
    a_boot_bounded: assert property (since_rst == BOOT_CYCLES |-> ##[0:3] load_allowed)
        else $error("boot too long");
    a_sleep_entry: assert property (pwr_ctrl_wr && pwr_ctrl_wdata[1] && cpu_run |=> asleep)
        else $error("sleep not entered");
    a_only_write_sleeps: assert property (!asleep && !pwr_ctrl_wr |=> !asleep)
        else $error("sleep without write");
    a_sleep_power_off: assert property (asleep |-> !(pll_en || crystal_drive_output_en
        || usb_xcvr_en || cpu_run))
        else $error("power on in sleep");
    a_booster_off: assert property (asleep |-> !booster_en)
        else $error("booster on in sleep");
    a_addr_low: assert property (asleep |-> mem_addr == '0)
        else $error("address not low");
    a_masked_stays: assert property (asleep && wake_enable == 8'hfe |=> asleep)
        else $error("woke while masked");
    a_wake_resume: assert property (wake_wait <= 13'd4002)
        else $error("resume too late");
    a_resume_irq: assert property (usb_resume |=> host_port_interrupt_line)
        else $error("no resume interrupt");
endmodule
`default_nettype wire

/* File: bench/boot_mode_sleep_wakeup_ctrl_bench.sv */
// Purpose: controller bench
// Assumes: 20-cycle boot
// Notes:   4000-cycle wake settle
`timescale 1ns/1ns
`default_nettype none
module boot_mode_sleep_wakeup_ctrl_bench;
    localparam logic [16:0] BOOT = 17'h14;
    logic sys_clk, rst_b, clock_source_select_pin, gpio_cfg_wr, eeprom_scl, eeprom_sda;
    logic role_id_input, pwr_ctrl_wr, usb_resume, bus_power_level, host_port_interrupt_line_ack;
    logic external_interrupt_zero, external_interrupt_one, hpi_read, hss_read, spi_read;
    logic boot_busy, load_allowed, coproc_mode, standalone_mode, ref_12mhz_ok, hpi_en;
    logic hss_en, spi_en, eeprom_en, strap_pins_released, dbg_uart_en, host_rd_dummy;
    logic first_dual_role_port_host, host_port_interrupt_line, asleep, cpu_run;
    logic cpu_clk_en, periph_clk_en, crystal_drive_output_en, pll_en, booster_en;
    logic usb_xcvr_en, dummy_seen;
    logic [1:0]  boot_strap_pins, boot_mode, app_strap_out, strap_pin_out;
    logic [2:0]  other_ports_host, rd_sel;
    logic [3:0]  cpu_speed;
    logic [7:0]  wake_enable;
    logic [15:0] pwr_ctrl_wdata, host_rd_data_in, host_rd_data;
    logic [18:0] cpu_mem_addr, mem_addr;
    logic [31:0] gpio_cfg_oe, gpio_oe;
    int          n_fail, checked, k, s, n;
    bmswc_top #(.BOOT_CYCLES(BOOT)) bmswc_top_inst (.*);
    bmswc_host_model bmswc_host_model_inst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic fire(input int i);
        case (i)
            0: usb_resume = 1'b1;
            1: bus_power_level = 1'b1;
            2: role_id_input = ~role_id_input;
            6: external_interrupt_one = ~external_interrupt_one;
            7: external_interrupt_zero = ~external_interrupt_zero;
            default: rd_sel = 3'h1 << (i - 3);
        endcase
        step(1);
        usb_resume = 1'b0;
        rd_sel = 3'h0;
    endtask
    always @(negedge sys_clk) begin
        if (host_rd_dummy === 1'b1) begin
            dummy_seen = 1'b1;
            chk(32'(host_rd_data), 32'h0, "dummy_data");
        end
    end
    initial begin
        {gpio_cfg_wr, pwr_ctrl_wr, usb_resume, host_port_interrupt_line_ack, bus_power_level} = 5'h0;
        {role_id_input, external_interrupt_zero, external_interrupt_one} = 3'h0;
        {eeprom_scl, eeprom_sda, app_strap_out, rd_sel} = 7'h38;
        {cpu_speed, wake_enable, gpio_cfg_oe, pwr_ctrl_wdata} = '0;
        cpu_mem_addr = 19'h1234;
        {n_fail, checked, dummy_seen} = '0;
        for (s = 0; s < 4; s++) begin
            rst_b = 1'b0;
            boot_strap_pins = 2'(s);
            clock_source_select_pin = s[0];
            step(10);
            rst_b = 1'b1;
            for (k = 0; k < 60 && load_allowed !== 1'b1; k++)
                step(1);
            chk(32'(k >= BOOT && k <= BOOT + 3), 32'h1, "boot_time");
            if (k == 60)
                tally_and_finish;
            boot_strap_pins = ~boot_strap_pins;
            step(2);
            chk(32'({boot_mode, strap_pins_released, boot_busy}), 32'(s * 4 + 2), "mode_kept");
            chk(32'({eeprom_en, spi_en, hss_en, hpi_en}), 32'h1 << s, "if_en");
            chk(32'({coproc_mode, standalone_mode}), (s == 3) ? 32'h1 : 32'h2, "mode");
            chk(32'(ref_12mhz_ok), 32'(s[0]), "ref_ok");
            chk(gpio_oe, (s == 3) ? 32'hd000_0000 : 32'h0, "gpio_oe");
            chk(32'(strap_pin_out), (s == 3) ? 32'h2 : 32'h3, "strap_out");
            chk(32'(dbg_uart_en), 32'(s == 3), "uart");
            chk(32'({first_dual_role_port_host, other_ports_host}), (s == 3) ? 32'h8 : 32'h0,
                "roles");
        end
        for (s = 0; s < 8; s++) begin
            pwr_ctrl_wdata = (s == 0) ? 16'hfffd : 16'h0002;
            pwr_ctrl_wr = 1'b1;
            step(1);
            pwr_ctrl_wdata = 16'h0002;
            pwr_ctrl_wr = (s == 0);
            gpio_cfg_oe = 32'hffff_ffff;
            step(1);
            {pwr_ctrl_wr, gpio_cfg_wr} = 2'h1;
            step(1);
            gpio_cfg_wr = 1'b0;
            chk(32'({asleep, pll_en, crystal_drive_output_en, booster_en, usb_xcvr_en,
                cpu_run}), 32'h20, "sleep_state");
            chk(32'(mem_addr), 32'h0, "mem_addr");
            chk(gpio_oe, 32'hd000_0000, "gpio_hold");
            wake_enable = ~(8'h1 << s);
            fire(s);
            step(3);
            chk(32'(asleep), 32'h1, "masked");
            wake_enable = 8'h1 << s;
            dummy_seen = 1'b0;
            fire(s);
            for (k = 0; k < 4100 && cpu_run !== 1'b1; k++)
                step(1);
            chk(32'(k >= 3990 && k <= 4005), 32'h1, "wake_time");
            if (k == 4100)
                tally_and_finish;
            chk(32'(dummy_seen), 32'(s >= 3 && s <= 5), "dummy");
            bus_power_level = 1'b0;
        end
        chk(32'(host_port_interrupt_line), 32'h1, "irq_set");
        host_port_interrupt_line_ack = 1'b1;
        step(1);
        host_port_interrupt_line_ack = 1'b0;
        step(1);
        chk(32'(host_port_interrupt_line), 32'h0, "irq_clr");
        cpu_speed = 4'h3;
        n = 0;
        repeat (16) begin
            step(1);
            n += (cpu_clk_en === 1'b1) + (periph_clk_en === 1'b1);
        end
        chk(32'(n), 32'd20, "cpu_div");
        tally_and_finish;
    end
endmodule
bind bmswc_top bmswc_props #(.MEM_AW(MEM_AW), .BOOT_CYCLES(BOOT_CYCLES)) bmswc_props_inst (.*);
`default_nettype wire

/* File: hdl/bmswc_delay.sv */
// Purpose: boot and PLL settle delay
// Assumes: tmr_start is a one-cycle pulse
// Notes:   tmr_done holds until the next start
`timescale 1ns/1ns
`default_nettype none
`include "bmswc_consts.svh"
module bmswc_delay (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // control
    bmswc_ctl_if.tmr  c
);
    logic [`BMSWC_TMR_W-1:0] remain;
    logic                    done;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            remain <= '0;
            done   <= 1'b0;
        end else if (c.tmr_start) begin
            remain <= c.tmr_cycles - `BMSWC_TMR_W'(1);
            done   <= 1'b0;
        end else if (remain != '0) begin
            remain <= remain - `BMSWC_TMR_W'(1);
        end else begin
            done <= 1'b1;
        end
    end

    assign c.tmr_done = done & ~c.tmr_start;
endmodule
`default_nettype wire

/* File: hdl/bmswc_top.sv */
// Purpose: boot, pin setup, sleep and wake sequencing
// Assumes: 20 MHz clock, synchronous inputs
// Notes:   software-facing controls are plain ports, no register bus
`timescale 1ns/1ns
`default_nettype none
`include "bmswc_consts.svh"
module bmswc_top #(
    parameter int unsigned      MEM_AW      = 19,
    parameter logic [16:0]      BOOT_CYCLES = 17'(`BMSWC_BOOT_CYCLES)
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // straps
    input  wire logic [1:0]        boot_strap_pins,
    input  wire logic              clock_source_select_pin,
    // boot status
    output logic [1:0]             boot_mode,
    output logic                   boot_busy,
    output logic                   load_allowed,
    output logic                   coproc_mode,
    output logic                   standalone_mode,
    output logic                   ref_12mhz_ok,
    // communication interface enables
    output logic                   hpi_en,
    output logic                   hss_en,
    output logic                   spi_en,
    output logic                   eeprom_en,
    // pin configuration
    input  wire logic              gpio_cfg_wr,
    input  wire logic [31:0]       gpio_cfg_oe,
    output logic [31:0]            gpio_oe,
    output logic                   strap_pins_released,
    output logic                   dbg_uart_en,
    // eeprom lines onto the strap pins
    input  wire logic              eeprom_scl,
    input  wire logic              eeprom_sda,
    input  wire logic [1:0]        app_strap_out,
    output logic [1:0]             strap_pin_out,
    // usb port roles
    input  wire logic              role_id_input,
    output logic                   first_dual_role_port_host,
    output logic [2:0]             other_ports_host,
    // power control and wake enables
    input  wire logic              pwr_ctrl_wr,
    input  wire logic [15:0]       pwr_ctrl_wdata,
    input  wire logic [7:0]        wake_enable,
    input  wire logic [3:0]        cpu_speed,
    // wake sources
    input  wire logic              usb_resume,
    input  wire logic              bus_power_level,
    input  wire logic              external_interrupt_zero,
    input  wire logic              external_interrupt_one,
    input  wire logic              hpi_read,
    input  wire logic              hss_read,
    input  wire logic              spi_read,
    // host read data
    input  wire logic [15:0]       host_rd_data_in,
    output logic [15:0]            host_rd_data,
    output logic                   host_rd_dummy,
    // host interrupt
    input  wire logic              host_port_interrupt_line_ack,
    output logic                   host_port_interrupt_line,
    // power domain controls
    output logic                   asleep,
    output logic                   cpu_run,
    output logic                   cpu_clk_en,
    output logic                   periph_clk_en,
    output logic                   crystal_drive_output_en,
    output logic                   pll_en,
    output logic                   booster_en,
    output logic                   usb_xcvr_en,
    // external memory address
    input  wire logic [MEM_AW-1:0] cpu_mem_addr,
    output logic [MEM_AW-1:0]      mem_addr
);
    bmswc_ctl_if ctl ();

    bmswc_pkg::bmswc_state_e state;
    bmswc_pkg::bmswc_state_e next_state;
    logic [1:0]              mode;
    logic                    alone;
    logic                    booted;
    logic [3:0]              div_cnt;
    logic                    sleep_req;
    logic                    wake_pend;
    logic                    stay_on;

    // ----
    // helpers
    // ----
    function automatic logic is_alone(input logic [1:0] m);
        return m == `BMSWC_MODE_ALONE;
    endfunction

    // ----
    // submodules
    // ----
    bmswc_delay u_delay (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .c       (ctl)
    );

    bmswc_wake u_wake (
        .sys_clk                 (sys_clk),
        .rst_b                   (rst_b),
        .usb_resume              (usb_resume),
        .bus_power_level         (bus_power_level),
        .role_id_input           (role_id_input),
        .external_interrupt_zero (external_interrupt_zero),
        .external_interrupt_one  (external_interrupt_one),
        .hpi_read                (hpi_read),
        .hss_read                (hss_read),
        .spi_read                (spi_read),
        .c                       (ctl)
    );

    // ----
    // sequencer
    // ----
    assign sleep_req = pwr_ctrl_wr & pwr_ctrl_wdata[`BMSWC_PWR_SLEEP_BIT]; // [R11]

    always_comb begin
        next_state = state;
        case (state)
            bmswc_pkg::BMSWC_ST_CAPTURE: begin
                next_state = bmswc_pkg::BMSWC_ST_BOOT;
            end
            bmswc_pkg::BMSWC_ST_BOOT: begin
                if (ctl.tmr_done) begin
                    next_state = bmswc_pkg::BMSWC_ST_RUN; // [R3] [R6]
                end
            end
            bmswc_pkg::BMSWC_ST_RUN: begin
                if (sleep_req) begin
                    next_state = bmswc_pkg::BMSWC_ST_SLEEP;
                end
            end
            bmswc_pkg::BMSWC_ST_SLEEP: begin
                if (ctl.wake_hit) begin
                    next_state = bmswc_pkg::BMSWC_ST_WAKE; // [R14]
                end
            end
            bmswc_pkg::BMSWC_ST_WAKE: begin
                if (ctl.tmr_done) begin
                    next_state = bmswc_pkg::BMSWC_ST_RUN; // [R16]
                end
            end
            default: begin
                next_state = bmswc_pkg::BMSWC_ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= bmswc_pkg::BMSWC_ST_CAPTURE;
        end else begin
            state <= next_state;
        end
    end

    // loads on boot and wake entry
    assign ctl.tmr_start  = (state == bmswc_pkg::BMSWC_ST_CAPTURE)
                          | (state == bmswc_pkg::BMSWC_ST_SLEEP && ctl.wake_hit);
    assign ctl.tmr_cycles = (state == bmswc_pkg::BMSWC_ST_CAPTURE) ? BOOT_CYCLES
                          : 17'(`BMSWC_WAKE_CYCLES); // [R16]
    assign ctl.armed      = (state == bmswc_pkg::BMSWC_ST_SLEEP);
    assign ctl.wake_en    = wake_enable;

    // ----
    // strap capture
    // ----
    // taken once after release; reset only clears
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode         <= `BMSWC_MODE_HPI;
            ref_12mhz_ok <= 1'b0;
        end else if (state == bmswc_pkg::BMSWC_ST_CAPTURE) begin
            mode         <= boot_strap_pins; // [R1] [R4]
            ref_12mhz_ok <= clock_source_select_pin; // [R18]
        end
    end

    assign alone = is_alone(mode);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            booted <= 1'b0;
        end else if (state == bmswc_pkg::BMSWC_ST_BOOT && ctl.tmr_done) begin
            booted <= 1'b1;
        end
    end

    // ----
    // boot status and interface enables
    // ----
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_mode       <= `BMSWC_MODE_HPI;
            coproc_mode     <= 1'b0;
            standalone_mode <= 1'b0;
            hpi_en          <= 1'b0;
            hss_en          <= 1'b0;
            spi_en          <= 1'b0;
            eeprom_en       <= 1'b0;
        end else begin
            boot_mode       <= mode; // [R2]
            coproc_mode     <= booted & ~alone; // [R5]
            standalone_mode <= booted & alone;
            hpi_en          <= booted & (mode == `BMSWC_MODE_HPI); // [R5]
            hss_en          <= booted & (mode == `BMSWC_MODE_HSS);
            spi_en          <= booted & (mode == `BMSWC_MODE_SPI);
            eeprom_en       <= booted & alone;
        end
    end

    assign boot_busy    = ~booted;
    assign load_allowed = booted; // [R6]

    // ----
    // pin configuration
    // ----
    // writes are dropped while asleep since the cpu that issues them is halted
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_oe <= `BMSWC_GPIO_OE_RST; // [R10]
        end else if (state == bmswc_pkg::BMSWC_ST_BOOT && ctl.tmr_done && alone) begin
            gpio_oe                      <= `BMSWC_GPIO_OE_RST;
            gpio_oe[`BMSWC_GPIO_SCL]     <= 1'b1; // [R7]
            gpio_oe[`BMSWC_GPIO_SDA]     <= 1'b1;
            gpio_oe[`BMSWC_GPIO_UART_TX] <= 1'b1; // [R8]
        end else if (gpio_cfg_wr && booted && !asleep) begin
            gpio_oe <= gpio_cfg_oe; // [R12]
        end
    end

    assign strap_pins_released = booted; // [R4]
    assign dbg_uart_en         = booted & alone; // [R8]

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_pin_out <= 2'h0;
        end else if (booted && alone) begin
            strap_pin_out <= {eeprom_sda, eeprom_scl}; // [R7]
        end else begin
            strap_pin_out <= app_strap_out;
        end
    end

    // ----
    // usb port roles
    // ----
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_dual_role_port_host <= 1'b0;
            other_ports_host          <= 3'h0;
        end else begin
            first_dual_role_port_host <= booted & alone & ~role_id_input; // [R9]
            other_ports_host          <= 3'h0; // [R10]
        end
    end

    // ----
    // power domain controls
    // ----
    assign asleep = (state == bmswc_pkg::BMSWC_ST_SLEEP);
    assign stay_on = (next_state != bmswc_pkg::BMSWC_ST_SLEEP);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crystal_drive_output_en <= 1'b1;
            pll_en                  <= 1'b1;
            booster_en              <= 1'b1;
            usb_xcvr_en             <= 1'b1;
        end else begin
            crystal_drive_output_en <= stay_on; // [R13]
            pll_en                  <= stay_on;
            booster_en              <= stay_on; // [R19]
            usb_xcvr_en             <= stay_on;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_run <= 1'b0;
        end else begin
            cpu_run <= (next_state == bmswc_pkg::BMSWC_ST_RUN); // [R14] [R16]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_addr <= '0;
        end else if (!stay_on) begin
            mem_addr <= '0; // [R12]
        end else begin
            mem_addr <= cpu_mem_addr;
        end
    end

    // ----
    // cpu clock divider
    // ----
    // only the cpu enable is divided; peripherals keep the full rate
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= `BMSWC_SPEED_RST;
        end else if (!cpu_run || div_cnt >= cpu_speed) begin
            div_cnt <= `BMSWC_SPEED_RST;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign cpu_clk_en    = cpu_run & (div_cnt >= cpu_speed); // [R17]
    assign periph_clk_en = 1'b1; // [R17]

    // ----
    // waking host read
    // ----
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_rd_data  <= `BMSWC_DUMMY_DATA;
            host_rd_dummy <= 1'b0;
        end else if (ctl.read_wake) begin
            host_rd_data  <= `BMSWC_DUMMY_DATA; // [R20]
            host_rd_dummy <= 1'b1;
        end else begin
            host_rd_data  <= host_rd_data_in;
            host_rd_dummy <= 1'b0;
        end
    end

    // ----
    // host port interrupt
    // ----
    // a resume in the ack cycle keeps the line set
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_pend <= 1'b0;
        end else if (usb_resume) begin
            wake_pend <= 1'b1; // [R21]
        end else if (host_port_interrupt_line_ack) begin
            wake_pend <= 1'b0;
        end
    end

    assign host_port_interrupt_line = wake_pend;
endmodule
`default_nettype wire

/* File: hdl/bmswc_wake.sv */
// Purpose: wakeup event detector
// Assumes: inputs synchronous to sys_clk
// Notes:   edges are tracked even while not armed so no stale edge fires
`timescale 1ns/1ns
`default_nettype none
`include "bmswc_consts.svh"
module bmswc_wake (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // sources
    input  wire logic usb_resume,
    input  wire logic bus_power_level,
    input  wire logic role_id_input,
    input  wire logic external_interrupt_zero,
    input  wire logic external_interrupt_one,
    input  wire logic hpi_read,
    input  wire logic hss_read,
    input  wire logic spi_read,
    // control
    bmswc_ctl_if.wak  c
);
    logic [2:0]             prev;
    logic [`BMSWC_WK_N-1:0] ev;
    logic [2:0]             cur;

    assign cur = {role_id_input, external_interrupt_one, external_interrupt_zero};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 3'h0;
        end else begin
            prev <= cur;
        end
    end

    always_comb begin
        ev                      = '0;
        ev[`BMSWC_WK_RESUME]    = usb_resume;
        ev[`BMSWC_WK_VBUS]      = bus_power_level;
        ev[`BMSWC_WK_ROLE]      = cur[2] ^ prev[2];
        ev[`BMSWC_WK_EXTERNAL_INTERRUPT_ONE]      = cur[1] ^ prev[1];
        ev[`BMSWC_WK_EXTERNAL_INTERRUPT_ZERO]      = cur[0] ^ prev[0];
        ev[`BMSWC_WK_HPI]       = hpi_read;
        ev[`BMSWC_WK_HSS]       = hss_read;
        ev[`BMSWC_WK_SPI]       = spi_read;
    end

    assign c.wake_hit  = c.armed & |(ev & c.wake_en); // [R15]
    assign c.read_wake = c.armed & |(ev[`BMSWC_WK_SPI:`BMSWC_WK_HPI]
                                     & c.wake_en[`BMSWC_WK_SPI:`BMSWC_WK_HPI]);
endmodule
`default_nettype wire

/* File: pkg/bmswc_consts.svh */
// What this block does
// [R1] Boot mode is taken from the two strap pins when reset is released.
// [R2] Strap 00 host port, 01 fast serial, 10 SPI slave, 11 standalone EEPROM.
// [R3] Internal boot procedure runs at most 3 ms after a reset event.
// [R4] Strap pins sampled only during boot, then released to the application.
// [R5] Non-standalone straps select coprocessor mode with only the matching interface.
// [R6] Code loading starts only after reset plus the 3 ms boot interval.
// [R7] Standalone boot drives the strap pins as EEPROM clock and data.
// [R8] Standalone boot assigns pins 28 and 27 to the debug UART.
// [R9] Standalone boot: pin 29 role id, high peripheral, low host.
// [R10] Standalone boot: other three ports peripheral, other pins stay inputs.
// [R11] Writing one to power control bit 1 enters sleep.
// [R12] Asleep: pin configuration kept, memory address outputs driven low.
// [R13] Asleep: crystal drive, PLL, booster and USB transceivers off.
// [R14] Asleep: processor suspended until an enabled wakeup event.
// [R15] Each wakeup source wakes only if enabled; edges, levels, reads.
// [R16] Code resumes within 200 us of wakeup, PLL settle time.
// [R17] Processor clock rate reducible without changing peripheral timing.
// [R18] Clock select pin sampled after reset; high means 12 MHz reference.
// [R19] Supply booster disabled whenever powered down.
// [R20] A waking host read returns discarded dummy data.
// [R21] Host port interrupt asserts on a USB resume.
//
// Purpose: controller constants
// Assumes: 20 MHz clock
// Notes:   definitions only
`ifndef BMSWC_CONSTS_SVH
`define BMSWC_CONSTS_SVH

`define BMSWC_CLK_MHZ        20
`define BMSWC_BOOT_US        3000
`define BMSWC_BOOT_CYCLES    (`BMSWC_BOOT_US * `BMSWC_CLK_MHZ)
`define BMSWC_WAKE_US        200
`define BMSWC_WAKE_CYCLES    (`BMSWC_WAKE_US * `BMSWC_CLK_MHZ)
`define BMSWC_TMR_W          17

`define BMSWC_MODE_HPI       2'h0
`define BMSWC_MODE_HSS       2'h1
`define BMSWC_MODE_SPI       2'h2
`define BMSWC_MODE_ALONE     2'h3

`define BMSWC_PWR_SLEEP_BIT  1
`define BMSWC_GPIO_SCL       30
`define BMSWC_GPIO_SDA       31
`define BMSWC_GPIO_ROLE      29
`define BMSWC_GPIO_UART_TX   28
`define BMSWC_GPIO_UART_RX   27
`define BMSWC_GPIO_OE_RST    32'h0000_0000

`define BMSWC_WK_RESUME      0
`define BMSWC_WK_VBUS        1
`define BMSWC_WK_ROLE        2
`define BMSWC_WK_HPI         3
`define BMSWC_WK_HSS         4
`define BMSWC_WK_SPI         5
`define BMSWC_WK_EXTERNAL_INTERRUPT_ONE        6
`define BMSWC_WK_EXTERNAL_INTERRUPT_ZERO        7
`define BMSWC_WK_N           8

`define BMSWC_DUMMY_DATA     16'h0000
`define BMSWC_SPEED_RST      4'h0

`endif

/* File: pkg/bmswc_ctl_if.sv */
// Purpose: controller to timer and wake carrier
// Assumes: one clock domain
// Notes:   tmr_start loads the counter
`timescale 1ns/1ns
`default_nettype none
`include "bmswc_consts.svh"
interface bmswc_ctl_if;
    logic                    tmr_start;
    logic [`BMSWC_TMR_W-1:0] tmr_cycles;
    logic                    tmr_done;
    logic                    armed;
    logic [`BMSWC_WK_N-1:0]  wake_en;
    logic                    wake_hit;
    logic                    read_wake;
    modport ctl (output tmr_start, tmr_cycles, armed, wake_en,
                 input tmr_done, wake_hit, read_wake);
    modport tmr (input tmr_start, tmr_cycles, output tmr_done);
    modport wak (input armed, wake_en, output wake_hit, read_wake);
endinterface
`default_nettype wire

/* File: pkg/bmswc_pkg.sv */
// Purpose: controller types
// Assumes: nothing
// Notes:   state codes left to the tool
package bmswc_pkg;
    typedef enum logic [2:0] {
        BMSWC_ST_CAPTURE,
        BMSWC_ST_BOOT,
        BMSWC_ST_RUN,
        BMSWC_ST_SLEEP,
        BMSWC_ST_WAKE
    } bmswc_state_e;
endpackage
